// ==== src/pbr_pkg.sv ====
// shared constants and carriers for the button and reset pin block
package pbr_pkg;

	// register byte addresses
	localparam logic [15:0] PBR_BTN_CTRL_ADDR  = 16'h4005;
	localparam logic [15:0] PBR_RST_CTRL_ADDR  = 16'h4006;
	localparam logic [15:0] PBR_IRQ_FLAG_ADDR  = 16'h4011;
	localparam logic [15:0] PBR_IRQ_MASK_ADDR  = 16'h4019;

	// field positions
	localparam int PBR_SECOND_ACT_LSB = 8;
	localparam int PBR_FIRST_ACT_LSB  = 4;
	localparam int PBR_LEVEL_STS_BIT  = 3;
	localparam int PBR_HOLD_TO_LSB    = 0;
	localparam int PBR_EDGE_FLAG_BIT  = 12;
	localparam int PBR_AUX_SLEEP_BIT  = 6;
	localparam int PBR_SLP_MASK_BIT   = 5;
	localparam int PBR_SLP_DRIVE_BIT  = 4;
	localparam int PBR_REL_DLY_LSB    = 0;

	// reset values
	localparam logic [1:0] PBR_FIRST_ACT_RST  = 2'h0;
	localparam logic [1:0] PBR_SECOND_ACT_RST = 2'h1;
	localparam logic [1:0] PBR_HOLD_TO_RST    = 2'h0;
	localparam logic [1:0] PBR_REL_DLY_RST    = 2'h3;
	localparam logic       PBR_MASK_RST       = 1'b1;
	localparam logic       PBR_SLEEP_BIT_RST  = 1'b1;

	// action encodings
	localparam logic [1:0] PBR_ACT_NONE = 2'h0; // second field: interrupt
	localparam logic [1:0] PBR_ACT_ON   = 2'h1;
	localparam logic [1:0] PBR_ACT_OFF  = 2'h2;

	// timing
	localparam longint PBR_CLK_HZ        = 100000000;
	localparam longint PBR_HOLD_BASE_S   = 1;
	localparam longint PBR_REL_DLY0_MS   = 3;
	localparam longint PBR_REL_DLY1_MS   = 11;
	localparam longint PBR_REL_DLY2_MS   = 51;
	localparam longint PBR_REL_DLY3_MS   = 101;
	localparam int     PBR_DEBOUNCE_CYC  = 2000;
	localparam int     PBR_HOLD_BASE_CYC = int'(PBR_HOLD_BASE_S * PBR_CLK_HZ);
	localparam int     PBR_REL_DLY0_CYC  = int'(PBR_REL_DLY0_MS * PBR_CLK_HZ / 1000);
	localparam int     PBR_REL_DLY1_CYC  = int'(PBR_REL_DLY1_MS * PBR_CLK_HZ / 1000);
	localparam int     PBR_REL_DLY2_CYC  = int'(PBR_REL_DLY2_MS * PBR_CLK_HZ / 1000);
	localparam int     PBR_REL_DLY3_CYC  = int'(PBR_REL_DLY3_MS * PBR_CLK_HZ / 1000);

	typedef enum logic [1:0] {
		PBR_PWR_OFF   = 2'b00,
		PBR_PWR_ON    = 2'b01,
		PBR_PWR_SLEEP = 2'b10
	} pbr_pwr_e;

	typedef enum logic [1:0] {
		PBR_HOLD_IDLE   = 2'b00,
		PBR_HOLD_SECOND = 2'b01,
		PBR_HOLD_THIRD  = 2'b10,
		PBR_HOLD_DONE   = 2'b11
	} pbr_hold_e;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} pbr_reg_req_s;

	typedef struct packed {
		logic on_req;
		logic off_req;
		logic hw_reset;
	} pbr_pwr_req_s;

endpackage : pbr_pkg

// ==== src/pbr_debounce.sv ====
`timescale 1ns/100ps
// level filter: a new level is taken only after it stays stable
module pbr_debounce #(
	parameter int FILTER_CYC = 2000
) (
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic raw_in,
	output logic      level_out
);
	import pbr_pkg::*;

	typedef struct packed {
		logic        level;
		logic [31:0] cnt;
	} pbr_deb_s;

	pbr_deb_s st_r;
	pbr_deb_s st_nxt;

	if (FILTER_CYC < 1) begin : g_chk
		$error("pbr_debounce: FILTER_CYC must be at least 1");
	end

	// count agreeing samples; any bounce restarts the wait
	always_comb begin
		st_nxt = st_r;
		if (raw_in == st_r.level) begin
			st_nxt.cnt = 32'h0;
		end else if (st_r.cnt >= 32'(FILTER_CYC - 1)) begin
			st_nxt.level = raw_in;
			st_nxt.cnt   = 32'h0;
		end else begin
			st_nxt.cnt = st_r.cnt + 32'h1;
		end
	end

	// idle level is high: both filtered pins rest deasserted
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			st_r <= '{level: 1'b1, cnt: 32'h0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level_out = st_r.level;

endmodule : pbr_debounce

// ==== src/pbr_delay_cnt.sv ====
`timescale 1ns/100ps
// one-shot down counter: load starts it, done pulses when it runs out
module pbr_delay_cnt #(
	parameter int W = 32
) (
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] value_in,
	input  wire logic         cancel_in,
	output logic              done_out,
	output logic              busy_out
);
	import pbr_pkg::*;

	typedef struct packed {
		logic         busy;
		logic         done;
		logic [W-1:0] cnt;
	} pbr_cnt_s;

	pbr_cnt_s st_r;
	pbr_cnt_s st_nxt;

	if (W < 2 || W > 32) begin : g_chk
		$error("pbr_delay_cnt: W must lie in 2..32");
	end

	// load wins over cancel so a restart is never lost
	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		if (load_in) begin
			st_nxt.busy = 1'b1;
			st_nxt.cnt  = value_in;
		end else if (cancel_in) begin
			st_nxt.busy = 1'b0;
		end else if (st_r.busy) begin
			if (st_r.cnt <= W'(1)) begin
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign done_out = st_r.done;
	assign busy_out = st_r.busy;

endmodule : pbr_delay_cnt

// ==== src/pbr_button_reset.sv ====
`timescale 1ns/100ps
module pbr_button_reset
	import pbr_pkg::*;
#(
	parameter int DEBOUNCE_CYC  = pbr_pkg::PBR_DEBOUNCE_CYC,
	parameter int HOLD_BASE_CYC = pbr_pkg::PBR_HOLD_BASE_CYC,
	parameter int REL_DLY0_CYC  = pbr_pkg::PBR_REL_DLY0_CYC,
	parameter int REL_DLY1_CYC  = pbr_pkg::PBR_REL_DLY1_CYC,
	parameter int REL_DLY2_CYC  = pbr_pkg::PBR_REL_DLY2_CYC,
	parameter int REL_DLY3_CYC  = pbr_pkg::PBR_REL_DLY3_CYC
) (
	input  wire logic                  clk_in,
	input  wire logic                  nrst_in,
	input  wire pbr_pkg::pbr_reg_req_s reg_req_in,
	input  wire logic                  user_unlocked_in,
	output logic [15:0]                reg_rdata_out,
	input  wire pbr_pkg::pbr_pwr_e     pwr_state_in,
	input  wire logic                  on_done_in,
	input  wire logic                  button_n_in,
	input  wire logic                  rst_pin_in,
	output logic                       rst_pin_out,
	output logic                       rst_pin_oe_out,
	output pbr_pkg::pbr_pwr_req_s      pwr_req_out,
	output logic                       button_irq_out,
	output logic                       on_state_out,
	output logic                       sleep_state_out,
	output logic                       aux_reset_out
);
	import pbr_pkg::*;

	typedef struct packed {
		logic [1:0]  first_act;
		logic [1:0]  second_act;
		logic [1:0]  hold_to;
		logic        edge_flag;
		logic        flag_mask;
		logic        aux_sleep;
		logic        sleep_mask;
		logic        sleep_drive;
		logic [1:0]  rel_dly;
		pbr_hold_e   phase;
		logic        rst_hold;
		logic        btn_prev;
		logic        rpin_prev;
		logic        on_req;
		logic        off_req;
		logic        hw_rst;
		logic        irq;
		logic        on_ind;
		logic        slp_ind;
		logic        aux_rst;
		logic        drive_low;
		logic [15:0] rdata;
	} pbr_core_s;

	localparam pbr_core_s CORE_RST = '{
		first_act:   PBR_FIRST_ACT_RST,
		second_act:  PBR_SECOND_ACT_RST,
		hold_to:     PBR_HOLD_TO_RST,
		edge_flag:   1'b0,
		flag_mask:   PBR_MASK_RST,
		aux_sleep:   PBR_SLEEP_BIT_RST,
		sleep_mask:  PBR_SLEEP_BIT_RST,
		sleep_drive: PBR_SLEEP_BIT_RST,
		rel_dly:     PBR_REL_DLY_RST,
		phase:       PBR_HOLD_IDLE,
		rst_hold:    1'b0,
		btn_prev:    1'b1,
		rpin_prev:   1'b1,
		on_req:      1'b0,
		off_req:     1'b0,
		hw_rst:      1'b0,
		irq:         1'b0,
		on_ind:      1'b0,
		slp_ind:     1'b0,
		aux_rst:     1'b1,
		drive_low:   1'b1,
		rdata:       16'h0
	};

	// the longest hold is eight base periods and must fit the counter
	if (HOLD_BASE_CYC < 1 || HOLD_BASE_CYC > 32'h0fffffff) begin : g_chk_hold
		$error("pbr_button_reset: HOLD_BASE_CYC out of range");
	end
	if (REL_DLY0_CYC < 1 || REL_DLY1_CYC < 1 || REL_DLY2_CYC < 1
		|| REL_DLY3_CYC < 1) begin : g_chk_rel
		$error("pbr_button_reset: release delays must be at least 1");
	end

	pbr_core_s   st_r;
	pbr_core_s   st_nxt;
	logic        btn_lvl;
	logic        rpin_lvl;
	logic        hold_load;
	logic        hold_cancel;
	logic [31:0] hold_val;
	logic        hold_done;
	logic        rel_load;
	logic [31:0] rel_val;
	logic        rel_done;
	logic        btn_fall;
	logic        btn_rise;
	logic        ext_rst;
	logic        locked_ok;

	pbr_debounce #(
		.FILTER_CYC (DEBOUNCE_CYC)
	) u_btn_deb (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.raw_in    (button_n_in),
		.level_out (btn_lvl)
	);

	// the reset pin is filtered too so glitches do not reboot the part
	pbr_debounce #(
		.FILTER_CYC (DEBOUNCE_CYC)
	) u_rpin_deb (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.raw_in    (rst_pin_in),
		.level_out (rpin_lvl)
	);

	pbr_delay_cnt #(
		.W (32)
	) u_hold_cnt (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.load_in   (hold_load),
		.value_in  (hold_val),
		.cancel_in (hold_cancel),
		.done_out  (hold_done),
		.busy_out  ()
	);

	pbr_delay_cnt #(
		.W (32)
	) u_rel_cnt (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.load_in   (rel_load),
		.value_in  (rel_val),
		.cancel_in (ext_rst),
		.done_out  (rel_done),
		.busy_out  ()
	);

	// edges of the filtered button, high level means released
	assign btn_fall = st_r.btn_prev && !btn_lvl;
	assign btn_rise = !st_r.btn_prev && btn_lvl;

	assign hold_val = 32'(HOLD_BASE_CYC) << st_r.hold_to;

	assign hold_load = btn_fall
		|| (hold_done && st_r.phase == PBR_HOLD_SECOND);
	assign hold_cancel = btn_rise;

	always_comb begin
		case (st_r.rel_dly)
			2'h0:    rel_val = 32'(REL_DLY0_CYC);
			2'h1:    rel_val = 32'(REL_DLY1_CYC);
			2'h2:    rel_val = 32'(REL_DLY2_CYC);
			default: rel_val = 32'(REL_DLY3_CYC);
		endcase
	end
	assign rel_load = on_done_in;

	// only a fall we did not cause counts as a request
	assign ext_rst = st_r.rpin_prev && !rpin_lvl && !st_r.drive_low
		&& !(pwr_state_in == PBR_PWR_SLEEP && st_r.sleep_mask);

	// locked fields only change once unlocked
	assign locked_ok = reg_req_in.wr && user_unlocked_in;

	always_comb begin
		st_nxt           = st_r;
		st_nxt.btn_prev  = btn_lvl;
		st_nxt.rpin_prev = rpin_lvl;
		st_nxt.on_req    = 1'b0;
		st_nxt.off_req   = 1'b0;
		st_nxt.hw_rst    = 1'b0;

		// register writes go first so hardware sets below can override
		if (locked_ok && reg_req_in.addr == PBR_BTN_CTRL_ADDR) begin
			st_nxt.second_act = reg_req_in.wdata[PBR_SECOND_ACT_LSB +: 2];
			st_nxt.first_act  = reg_req_in.wdata[PBR_FIRST_ACT_LSB +: 2];
			st_nxt.hold_to    = reg_req_in.wdata[PBR_HOLD_TO_LSB +: 2];
		end
		if (locked_ok && reg_req_in.addr == PBR_RST_CTRL_ADDR) begin
			st_nxt.aux_sleep   = reg_req_in.wdata[PBR_AUX_SLEEP_BIT];
			st_nxt.sleep_mask  = reg_req_in.wdata[PBR_SLP_MASK_BIT];
			st_nxt.sleep_drive = reg_req_in.wdata[PBR_SLP_DRIVE_BIT];
			st_nxt.rel_dly     = reg_req_in.wdata[PBR_REL_DLY_LSB +: 2];
		end
		// mask is not behind the key
		if (reg_req_in.wr && reg_req_in.addr == PBR_IRQ_MASK_ADDR) begin
			st_nxt.flag_mask = reg_req_in.wdata[PBR_EDGE_FLAG_BIT];
		end
		if (reg_req_in.wr && reg_req_in.addr == PBR_IRQ_FLAG_ADDR
			&& reg_req_in.wdata[PBR_EDGE_FLAG_BIT]) begin
			st_nxt.edge_flag = 1'b0;
		end

		// both edges raise the event; set beats clear
		if (btn_fall || btn_rise) begin
			st_nxt.edge_flag = 1'b1;
		end

		if (btn_fall) begin
			st_nxt.on_req  = (st_r.first_act == PBR_ACT_ON);
			st_nxt.off_req = (st_r.first_act == PBR_ACT_OFF);
		end

		// hold sequence: second then third action
		case (st_r.phase)
			PBR_HOLD_IDLE: begin
				if (btn_fall) begin
					st_nxt.phase = PBR_HOLD_SECOND;
				end
			end
			PBR_HOLD_SECOND: begin
				if (btn_rise) begin
					st_nxt.phase = PBR_HOLD_IDLE;
				end else if (hold_done) begin
					st_nxt.phase = PBR_HOLD_THIRD;
					case (st_r.second_act)
						PBR_ACT_NONE: st_nxt.edge_flag = 1'b1;
						PBR_ACT_ON:   st_nxt.on_req = 1'b1;
						PBR_ACT_OFF:  st_nxt.off_req = 1'b1;
						default:      ;
					endcase
				end
			end
			PBR_HOLD_THIRD: begin
				if (btn_rise) begin
					st_nxt.phase = PBR_HOLD_IDLE;
				end else if (hold_done) begin
					st_nxt.phase   = PBR_HOLD_DONE;
					st_nxt.off_req = 1'b1;
				end
			end
			PBR_HOLD_DONE: begin
				if (btn_rise) begin
					st_nxt.phase = PBR_HOLD_IDLE;
				end
			end
			default: st_nxt.phase = PBR_HOLD_IDLE;
		endcase
		// a fresh press during any phase restarts the sequence
		if (btn_fall) begin
			st_nxt.phase = PBR_HOLD_SECOND;
		end

		// external reset returns registers to defaults
		// the request makes the sequencer go OFF then ON
		// done before the pin and indicators so they keep the power state
		if (ext_rst) begin
			st_nxt           = CORE_RST;
			st_nxt.btn_prev  = btn_lvl;
			st_nxt.rpin_prev = rpin_lvl;
			st_nxt.hw_rst    = 1'b1;
		end

		// keep pin low until the delay runs out
		if (on_done_in) begin
			st_nxt.rst_hold = 1'b1;
		end else if (rel_done) begin
			st_nxt.rst_hold = 1'b0;
		end

		case (pwr_state_in)
			PBR_PWR_OFF:   st_nxt.drive_low = 1'b1;
			PBR_PWR_SLEEP: st_nxt.drive_low = st_r.sleep_drive;
			default:       st_nxt.drive_low = st_nxt.rst_hold;
		endcase

		st_nxt.on_ind  = (pwr_state_in == PBR_PWR_ON);
		st_nxt.slp_ind = (pwr_state_in == PBR_PWR_SLEEP);
		// aux reset in OFF, bit in SLEEP
		case (pwr_state_in)
			PBR_PWR_OFF:   st_nxt.aux_rst = 1'b1;
			PBR_PWR_SLEEP: st_nxt.aux_rst = st_r.aux_sleep;
			default:       st_nxt.aux_rst = 1'b0;
		endcase

		// masked flag cannot reach the interrupt
		st_nxt.irq = st_nxt.edge_flag && !st_nxt.flag_mask;

		// readback; unmapped addresses read zero
		if (reg_req_in.rd) begin
			st_nxt.rdata = 16'h0;
			case (reg_req_in.addr)
				PBR_BTN_CTRL_ADDR: begin
					st_nxt.rdata[PBR_SECOND_ACT_LSB +: 2] = st_r.second_act;
					st_nxt.rdata[PBR_FIRST_ACT_LSB +: 2]  = st_r.first_act;
					st_nxt.rdata[PBR_LEVEL_STS_BIT]       = btn_lvl;
					st_nxt.rdata[PBR_HOLD_TO_LSB +: 2]    = st_r.hold_to;
				end
				PBR_RST_CTRL_ADDR: begin
					st_nxt.rdata[PBR_AUX_SLEEP_BIT]     = st_r.aux_sleep;
					st_nxt.rdata[PBR_SLP_MASK_BIT]      = st_r.sleep_mask;
					st_nxt.rdata[PBR_SLP_DRIVE_BIT]     = st_r.sleep_drive;
					st_nxt.rdata[PBR_REL_DLY_LSB +: 2]  = st_r.rel_dly;
				end
				PBR_IRQ_FLAG_ADDR:
					st_nxt.rdata[PBR_EDGE_FLAG_BIT] = st_r.edge_flag;
				PBR_IRQ_MASK_ADDR:
					st_nxt.rdata[PBR_EDGE_FLAG_BIT] = st_r.flag_mask;
				default: st_nxt.rdata = 16'h0;
			endcase
		end
	end

	// the pin comes up driven low so nothing downstream starts early
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			st_r <= CORE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// open drain: only ever pull low
	assign rst_pin_out          = 1'b0;
	assign rst_pin_oe_out       = st_r.drive_low;
	assign reg_rdata_out        = st_r.rdata;
	assign pwr_req_out.on_req   = st_r.on_req;
	assign pwr_req_out.off_req  = st_r.off_req;
	assign pwr_req_out.hw_reset = st_r.hw_rst;
	assign button_irq_out       = st_r.irq;
	assign on_state_out         = st_r.on_ind;
	assign sleep_state_out      = st_r.slp_ind;
	assign aux_reset_out        = st_r.aux_rst;

endmodule : pbr_button_reset

// ==== dv/pbr_far_side.sv ====
`timescale 1ns/100ps
// power switch and the shared reset line, as the board presents them
module pbr_far_side (
	input  wire logic press_in,
	input  wire logic ext_rst_in,
	input  wire logic rst_oe_in,
	output logic      button_n_out,
	output logic      rst_wire_out
);
	assign button_n_out = ~press_in;
	assign rst_wire_out = ~(rst_oe_in | ext_rst_in);
endmodule : pbr_far_side

// ==== dv/pbr_button_reset_sva.sv ====
`timescale 1ns/100ps
// port-level watch on the button and reset pin block
module pbr_button_reset_sva
	import pbr_pkg::*;
#(
	parameter int DEBOUNCE_CYC = 2000
) (
	input wire logic                  clk_in,
	input wire logic                  nrst_in,
	input wire pbr_pkg::pbr_reg_req_s reg_req_in,
	input wire pbr_pkg::pbr_pwr_e     pwr_state_in,
	input wire logic                  on_done_in,
	input wire logic                  button_n_in,
	input wire logic                  rst_pin_in,
	input wire logic                  rst_pin_out,
	input wire logic                  rst_pin_oe_out,
	input wire pbr_pkg::pbr_pwr_req_s pwr_req_out,
	input wire logic                  button_irq_out,
	input wire logic                  on_state_out,
	input wire logic                  sleep_state_out,
	input wire logic                  aux_reset_out
);
	logic [15:0] low_cnt_r;
	logic [15:0] low_cnt_nxt;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	// low run length on the wire; saturates so long holds never wrap
	always_comb begin
		low_cnt_nxt = low_cnt_r;
		if (rst_pin_in)
			low_cnt_nxt = 16'h0;
		else if (!(&low_cnt_r))
			low_cnt_nxt = low_cnt_r + 16'h1;
	end
	always_ff @(posedge clk_in) begin
		if (!nrst_in)
			low_cnt_r <= 16'h0;
		else
			low_cnt_r <= low_cnt_nxt;
	end

	sequence s_idle8;
		(button_n_in && rst_pin_in)[*8];
	endsequence

	property p_off_drive;
		pwr_state_in == PBR_PWR_OFF |=> rst_pin_oe_out && !rst_pin_out;
	endproperty
	a_off_drive: assert property (p_off_drive)
		else $error("reset pin not driven low in off");
	property p_aux_off;
		pwr_state_in == PBR_PWR_OFF |=> aux_reset_out;
	endproperty
	a_aux_off: assert property (p_aux_off)
		else $error("aux reset not asserted in off");
	property p_on_ind;
		pwr_state_in == PBR_PWR_ON |=> on_state_out && !sleep_state_out;
	endproperty
	a_on_ind: assert property (p_on_ind)
		else $error("on indicator wrong");
	property p_slp_ind;
		pwr_state_in == PBR_PWR_SLEEP |=> sleep_state_out && !on_state_out;
	endproperty
	a_slp_ind: assert property (p_slp_ind)
		else $error("sleep indicator wrong");
	property p_rel_hold;
		on_done_in && pwr_state_in == PBR_PWR_ON |=> rst_pin_oe_out[*4];
	endproperty
	a_rel_hold: assert property (p_rel_hold)
		else $error("reset pin released early");
	property p_rel_end;
		(on_done_in && pwr_state_in == PBR_PWR_ON) ##1
		(pwr_state_in == PBR_PWR_ON && !on_done_in)[*8]
		|-> ##[0:6] !rst_pin_oe_out;
	endproperty
	a_rel_end: assert property (p_rel_end)
		else $error("reset pin never released");
	property p_hw_rst;
		pwr_req_out.hw_reset |-> $past(low_cnt_r) >= 16'(DEBOUNCE_CYC - 1);
	endproperty
	a_hw_rst: assert property (p_hw_rst)
		else $error("hardware reset without filtered low");
	property p_irq_hold;
		button_irq_out && !reg_req_in.wr && rst_pin_in |=> button_irq_out;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("irq dropped without clear");
	property p_idle_quiet;
		s_idle8 |-> !pwr_req_out.on_req && !pwr_req_out.off_req;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("request with button released");
	property p_req_pulse;
		pwr_req_out.off_req |=> !pwr_req_out.off_req;
	endproperty
	a_req_pulse: assert property (p_req_pulse)
		else $error("off request longer than a cycle");

	// main scenarios reached
	c_on_req: cover property (pwr_req_out.on_req);
	c_hw_rst: cover property (pwr_req_out.hw_reset);
	c_rel: cover property ($fell(rst_pin_oe_out));
endmodule : pbr_button_reset_sva

bind pbr_button_reset pbr_button_reset_sva #(
	.DEBOUNCE_CYC(DEBOUNCE_CYC)
) pbr_button_reset_sva_inst (
	.clk_in(clk_in),
	.nrst_in(nrst_in),
	.reg_req_in(reg_req_in),
	.pwr_state_in(pwr_state_in),
	.on_done_in(on_done_in),
	.button_n_in(button_n_in),
	.rst_pin_in(rst_pin_in),
	.rst_pin_out(rst_pin_out),
	.rst_pin_oe_out(rst_pin_oe_out),
	.pwr_req_out(pwr_req_out),
	.button_irq_out(button_irq_out),
	.on_state_out(on_state_out),
	.sleep_state_out(sleep_state_out),
	.aux_reset_out(aux_reset_out)
);

// ==== dv/pbr_button_reset_bench.sv ====
`timescale 1ns/100ps
// self-checking bench for the button and reset pin block
module pbr_button_reset_bench;
	import pbr_pkg::*;

	logic         clk_in;
	logic         nrst_in;
	pbr_reg_req_s req;
	logic         unl;
	pbr_pwr_e     pwr;
	logic         on_done;
	logic         press;
	logic         ext;
	logic [15:0]  rdata;
	logic         btn_n;
	logic         rst_wire;
	logic         pin_o;
	logic         oe;
	pbr_pwr_req_s preq;
	logic         irq;
	logic         on_st;
	logic         slp_st;
	logic         aux;
	int           fail_count;
	int           checks_done;
	int           n_on;
	int           n_off;
	int           n_hw;
	int           cyc;

	// base hold period shared by the instance and the expectations
	localparam int HOLD_CYC = 20;

	// short counts keep the run small
	pbr_button_reset #(
		.DEBOUNCE_CYC(4),
		.HOLD_BASE_CYC(HOLD_CYC),
		.REL_DLY0_CYC(5),
		.REL_DLY1_CYC(6),
		.REL_DLY2_CYC(7),
		.REL_DLY3_CYC(8)
	) pbr_button_reset_inst (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.reg_req_in(req),
		.user_unlocked_in(unl),
		.reg_rdata_out(rdata),
		.pwr_state_in(pwr),
		.on_done_in(on_done),
		.button_n_in(btn_n),
		.rst_pin_in(rst_wire),
		.rst_pin_out(pin_o),
		.rst_pin_oe_out(oe),
		.pwr_req_out(preq),
		.button_irq_out(irq),
		.on_state_out(on_st),
		.sleep_state_out(slp_st),
		.aux_reset_out(aux)
	);
	pbr_far_side pbr_far_side_inst (
		.press_in(press),
		.ext_rst_in(ext),
		.rst_oe_in(oe),
		.button_n_out(btn_n),
		.rst_wire_out(rst_wire)
	);

	// 100 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// request pulse counts and the hang guard
	always @(posedge clk_in) begin
		n_on <= n_on + int'(preq.on_req === 1'b1);
		n_off <= n_off + int'(preq.off_req === 1'b1);
		n_hw <= n_hw + int'(preq.hw_reset === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			$display("mismatch at %0t: run hung", $time);
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask : tick

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// one register write; an idle cycle follows so strobes never merge
	task automatic wr(input logic [15:0] a, input logic [15:0] d,
		input logic u);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		unl <= u;
		tick(1);
		req.wr <= 1'b0;
		unl <= 1'b0;
		tick(1);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
		tick(1);
		req.rd <= 1'b0;
		tick(1);
		chk(rdata, exp, "read data");
	endtask : rd

	task automatic t_defaults;
		rd(PBR_BTN_CTRL_ADDR, 16'h0108); // defaults
		rd(PBR_RST_CTRL_ADDR, 16'h0073); // defaults
		rd(PBR_IRQ_FLAG_ADDR, 16'h0000); // flag clear
		rd(PBR_IRQ_MASK_ADDR, 16'h1000); // masked
		rd(16'h4000, 16'h0000);
		$display("test defaults done");
	endtask : t_defaults

	task automatic t_lock;
		wr(PBR_BTN_CTRL_ADDR, 16'h0221, 1'b0); // locked write
		rd(PBR_BTN_CTRL_ADDR, 16'h0108); // unchanged
		wr(PBR_RST_CTRL_ADDR, 16'h0000, 1'b0); // locked write
		rd(PBR_RST_CTRL_ADDR, 16'h0073); // unchanged
		wr(PBR_BTN_CTRL_ADDR, 16'h0000, 1'b1);
		rd(PBR_BTN_CTRL_ADDR, 16'h0008); // status bit read-only
		$display("test lock done");
	endtask : t_lock

	// every action and timeout code, released before the third action
	task automatic t_button;
		int per;
		int on0;
		int off0;
		logic [1:0] a;
		wr(PBR_IRQ_MASK_ADDR, 16'h0000, 1'b0);
		for (int i = 0; i < 4; i++) begin
			a = 2'(i);
			per = HOLD_CYC << i;
			wr(PBR_BTN_CTRL_ADDR, {6'h0, a, 2'h0, a, 2'h0, a}, 1'b1);
			wr(PBR_IRQ_FLAG_ADDR, 16'h1000, 1'b0);
			on0 = n_on;
			off0 = n_off;
			press <= 1'b1;
			tick(10);
			chk(16'(irq), 16'h1, "press irq");
			rd(PBR_BTN_CTRL_ADDR, {6'h0, a, 2'h0, a, 2'h0, a});
			wr(PBR_IRQ_FLAG_ADDR, 16'h1000, 1'b0);
			chk(16'(n_on - on0), 16'(a == 2'h1), "first on");
			chk(16'(n_off - off0), 16'(a == 2'h2), "first off");
			tick(per - 14);
			chk(16'(irq), 16'h0, "flag cleared");
			chk(16'(n_on - on0), 16'(a == 2'h1), "early");
			tick(14);
			chk(16'(n_on - on0), 16'(2 * (a == 2'h1)), "second on");
			chk(16'(n_off - off0), 16'(2 * (a == 2'h2)), "second off");
			chk(16'(irq), 16'(a == 2'h0), "second irq");
			wr(PBR_IRQ_FLAG_ADDR, 16'h1000, 1'b0);
			press <= 1'b0;
			tick(10);
			chk(16'(irq), 16'h1, "release irq");
			tick(per + 10);
			chk(16'(n_off - off0), 16'(2 * (a == 2'h2)), "cancel");
		end
		$display("test button done");
	endtask : t_button

	task automatic t_third;
		int off0;
		wr(PBR_BTN_CTRL_ADDR, 16'h0000, 1'b1);
		off0 = n_off;
		press <= 1'b1;
		tick(60);
		chk(16'(n_off - off0), 16'h1, "third off");
		tick(40);
		chk(16'(n_off - off0), 16'h1, "no fourth");
		press <= 1'b0;
		tick(10);
		$display("test third done");
	endtask : t_third

	task automatic t_states;
		pwr <= PBR_PWR_ON;
		tick(3);
		chk(16'({on_st, slp_st, aux, oe}), 16'h8, "on");
		pwr <= PBR_PWR_SLEEP;
		tick(3);
		chk(16'({on_st, slp_st, aux, oe}), 16'h7, "sleep");
		wr(PBR_RST_CTRL_ADDR, 16'h0020, 1'b1);
		tick(1);
		chk(16'({on_st, slp_st, aux, oe}), 16'h4, "sleep off");
		pwr <= PBR_PWR_OFF;
		tick(3);
		chk(16'({on_st, slp_st, aux, oe}), 16'h3, "off");
		$display("test states done");
	endtask : t_states

	task automatic t_release;
		for (int i = 0; i < 4; i++) begin
			wr(PBR_RST_CTRL_ADDR, {12'h007, 2'h0, 2'(i)}, 1'b1);
			pwr <= PBR_PWR_OFF;
			tick(2);
			pwr <= PBR_PWR_ON;
			on_done <= 1'b1;
			tick(1);
			on_done <= 1'b0;
			tick(4 + i);
			chk(16'(oe), 16'h1, "still held");
			tick(5);
			chk(16'(oe), 16'h0, "released");
		end
		$display("test release done");
	endtask : t_release

	// pull the shared line low for a while, then let it float
	task automatic ext_pulse;
		ext <= 1'b1;
		tick(8);
		ext <= 1'b0;
		tick(8);
	endtask : ext_pulse

	task automatic t_ext;
		int hw0;
		hw0 = n_hw;
		wr(PBR_RST_CTRL_ADDR, 16'h0000, 1'b1);
		ext_pulse();
		chk(16'(n_hw - hw0), 16'h1, "hw reset");
		rd(PBR_RST_CTRL_ADDR, 16'h0073); // registers restored
		wr(PBR_RST_CTRL_ADDR, 16'h0020, 1'b1);
		pwr <= PBR_PWR_SLEEP;
		tick(8);
		ext_pulse();
		chk(16'(n_hw - hw0), 16'h1, "masked");
		wr(PBR_RST_CTRL_ADDR, 16'h0000, 1'b1);
		tick(8);
		ext_pulse();
		chk(16'(n_hw - hw0), 16'h2, "unmasked");
		pwr <= PBR_PWR_OFF;
		tick(3);
		$display("test external reset done");
	endtask : t_ext

	// reset, then the scenarios in turn
	initial begin
		nrst_in = 1'b0;
		req = '0;
		unl = 1'b0;
		pwr = PBR_PWR_OFF;
		on_done = 1'b0;
		press = 1'b0;
		ext = 1'b0;
		fail_count = 0;
		checks_done = 0;
		n_on = 0;
		n_off = 0;
		n_hw = 0;
		cyc = 0;
		tick(3);
		nrst_in <= 1'b1;
		tick(8);
		t_defaults();
		t_lock();
		t_button();
		t_third();
		t_states();
		t_release();
		t_ext();
		report_and_stop();
	end
endmodule : pbr_button_reset_bench
